// >>> ees_i2c_master.sv
// bus master model for the two-wire eeprom slave, 160 ns bit period
// assumes the bench resolves sda from both pull enables with a pull-up
`timescale 1ns/100ps
`default_nettype none

module ees_i2c_master (
    // serial link
    output var logic sclOut,
    output var logic sdaPull,
    input  wire logic sdaWire
);
    // scl stands high outside frames, sda released
    initial begin
        sclOut  = 1'b1;
        sdaPull = 1'b0;
    end

    // one bit: sda moves 40 ns after the fall, sampled at the rise
    task automatic bitX(input logic b, output logic s);
        sclOut = 1'b0;
        #40 sdaPull = ~b;
        #40 sclOut = 1'b1;
        s = sdaWire;
        #80;
    endtask

    // start, or repeated start when rep is set
    task automatic startF(input logic rep);
        if (rep) begin
            sclOut = 1'b0;
            #40 sdaPull = 1'b0;
            #40 sclOut = 1'b1;
        end
        #80 sdaPull = 1'b1;
        #80 sclOut = 1'b0;
    endtask

    // stop, then the bus free time before anything new
    task automatic stopF;
        sclOut = 1'b0;
        #40 sdaPull = 1'b1;
        #40 sclOut = 1'b1;
        #80 sdaPull = 1'b0;
        #160;
    endtask

    // byte out, then ninth clock with sda released
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitX(d[i], s);
        end
        bitX(1'b1, s);
        ack = ~s;
    endtask

    // byte in; more=1 acks to ask for another byte
    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitX(1'b1, s);
            d[i] = s;
        end
        bitX(~more, s);
    endtask
endmodule

`default_nettype wire

// >>> ees_pkg.sv
// constants and types for the two-wire serial eeprom slave
// assumes a 250 MHz system clock and a master-driven serial clock
package ees_pkg;

    // addressing of the device and the array
    localparam logic [3:0] EES_DEV_PREFIX = 4'ha;
    localparam logic       EES_DIR_READ   = 1'h1;
    localparam int         EES_ADDR_W     = 12;
    localparam int         EES_OFF_W      = 5;
    localparam int         EES_HI_W       = 4;
    localparam int         EES_MEM_DEPTH  = 4096;
    localparam int         EES_PAGE_BYTES = 32;
    localparam logic [7:0] EES_ERASED     = 8'hff;

    // bit and page counters
    localparam logic [2:0] EES_LAST_BIT = 3'h7;
    localparam logic [4:0] EES_LAST_OFF = 5'h1f;

    // write cycle time in its own unit and as clock cycles
    localparam int EES_TWR_US     = 4000;
    localparam int EES_CLK_MHZ    = 250;
    localparam int EES_TWR_CYCLES = EES_TWR_US * EES_CLK_MHZ;
    localparam int EES_BUSY_W     = 20;

    // pin group that passes the synchroniser together
    typedef struct packed {
        logic [2:0] strap;
        logic       wp;
        logic       sda;
        logic       scl;
    } ees_pins_t;

    // idle bus level, so reset makes no false edge
    localparam ees_pins_t EES_PINS_IDLE = '{
        strap: 3'h0, wp: 1'h0, sda: 1'h1, scl: 1'h1};

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_RXBYTE, ST_RXACK, ST_TXBYTE, ST_TXACK, ST_IGNORE
    } ees_state_t;

    // meaning of the next received byte
    typedef enum logic [1:0] {
        KD_DEV, KD_ADRH, KD_ADRL, KD_DATA
    } ees_kind_t;

endpackage

// >>> ees_slave.sv
// two-wire serial slave with a 4096-byte array and page buffer
// assumes scl/sda pins are resolved outside; the bench resolves the
// open-drain wire from sdaOe, and scl is free of glitches
`timescale 1ns/100ps
`default_nettype none

module ees_slave
    import ees_pkg::*;
#(
    parameter int WRITE_CYCLES = EES_TWR_CYCLES
) (
    // clock, reset, freeze
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // serial link
    input  wire logic scl,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    // strap and protect pins
    input  wire logic writeProtect,
    input  wire logic strapSelectBit0,
    input  wire logic strapSelectBit1,
    input  wire logic strapSelectBit2,
    // status
    output logic      writeBusy
);

    // synchroniser stages and delayed copies
    ees_pins_t pinsRaw;             // raw pin group
    ees_pins_t sync1_r;             // first stage, read only by sync2
    ees_pins_t sync2_r;             // second stage, safe to use
    logic      sclD_r;              // scl one cycle later
    logic      sdaD_r;              // sda one cycle later
    logic      sdaD2_r;             // sda two cycles later

    // link-clock side: byte capture
    logic [7:0] rxShift_r;          // bits captured on scl rise

    // protocol state
    ees_state_t            state_r;  // bit-level state
    ees_kind_t             kind_r;   // next byte's meaning
    logic [2:0]            bitCnt_r; // bit within byte
    logic                  toTx_r;   // ack leads to sending
    logic                  gotAck_r; // master acked our byte
    logic [EES_ADDR_W-1:0] addr_r;   // internal pointer
    logic [7:0]            txSh_r;   // outgoing bits

    // write path
    logic [7:0]            pageBuf [EES_PAGE_BYTES]; // page buffer
    logic [EES_PAGE_BYTES-1:0] valid_r;  // loaded offsets
    logic                  wpLat_r;      // protect strobe
    logic                  commitAct_r;  // copying buffer
    logic [EES_OFF_W-1:0]  commitIdx_r;  // offset being copied
    logic [EES_BUSY_W-1:0] busyCnt_r;    // write cycle timer

    // the array itself, delivered erased; reset leaves it alone
    // one writer only: the erased image is the declaration value
    logic [7:0] mem [EES_MEM_DEPTH] = '{default: EES_ERASED};

    // decoded events
    logic                  sclRise;
    logic                  sclFall;
    logic                  startEv;
    logic                  stopEv;
    logic                  byteDone;
    logic                  devMatch;
    logic                  storeEv;
    logic                  txLoad;
    logic                  wpStrobe;
    logic [7:0]            memByte;
    logic [EES_OFF_W-1:0]  offNext;

    assign pinsRaw = '{strap: {strapSelectBit2, strapSelectBit1,
                               strapSelectBit0},
                       wp: writeProtect, sda: sdaIn, scl: scl};

    // two-stage synchroniser on every pin from outside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= EES_PINS_IDLE;
            sync2_r <= EES_PINS_IDLE;
        end else if (ce) begin
            sync1_r <= pinsRaw;
            sync2_r <= sync1_r;
        end
    end

    // delayed copies for edge detection
    // sda is delayed one stage more than scl: a master that moves
    // sda right at the scl fall is then never mistaken for start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclD_r  <= 1'h1;
            sdaD_r  <= 1'h1;
            sdaD2_r <= 1'h1;
        end else if (ce) begin
            sclD_r  <= sync2_r.scl;
            sdaD_r  <= sync2_r.sda;
            sdaD2_r <= sdaD_r;
        end
    end

    // capture on the link clock itself; the clk side reads it only
    // a few cycles after the eighth rise, while it stands still
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            rxShift_r <= 8'h00;
        end else begin
            rxShift_r <= {rxShift_r[6:0], sdaIn};
        end
    end

    // bus conditions, both seen with scl high twice running
    assign sclRise = sync2_r.scl & ~sclD_r;
    assign sclFall = ~sync2_r.scl & sclD_r;
    assign startEv = sync2_r.scl & sclD_r & sdaD2_r & ~sdaD_r;
    assign stopEv  = sync2_r.scl & sclD_r & ~sdaD2_r & sdaD_r;

    // byte complete after the eighth rise
    assign byteDone = (state_r == ST_RXBYTE) && sclRise
                      && (bitCnt_r == EES_LAST_BIT);

    // prefix, straps; a busy device answers nobody
    assign devMatch = (rxShift_r[7:4] == EES_DEV_PREFIX)
                      && (rxShift_r[3:1] == sync2_r.strap)
                      && !writeBusy;

    // data byte accepted into the page buffer
    assign storeEv = byteDone && (kind_r == KD_DATA) && !wpLat_r;

    // fetch of a byte to send, on the fall ending an ack
    assign txLoad = sclFall
                    && (((state_r == ST_RXACK) && sdaOe && toTx_r)
                        || ((state_r == ST_TXACK) && gotAck_r));

    // last fall before the first data byte: end of the low ack
    assign wpStrobe = sclFall && (state_r == ST_RXACK) && sdaOe
                      && (kind_r == KD_DATA) && (valid_r == '0);

    assign memByte = mem[addr_r];
    assign offNext = addr_r[EES_OFF_W-1:0] + 5'h01;

    // protocol engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r  <= ST_IDLE;
            kind_r   <= KD_DEV;
            bitCnt_r <= 3'h0;
            toTx_r   <= 1'h0;
            gotAck_r <= 1'h0;
            addr_r   <= '0;
            txSh_r   <= 8'h00;
            sdaOe    <= 1'h0;
        end else if (ce) begin
            if (startEv) begin
                // start or repeated start: expect an address
                state_r  <= ST_RXBYTE;
                kind_r   <= KD_DEV;
                bitCnt_r <= 3'h0;
                sdaOe    <= 1'h0;
            end else if (stopEv) begin
                // stop ends any command and frees the line
                state_r <= ST_IDLE;
                sdaOe   <= 1'h0;
            end else begin
                case (state_r)
                    ST_IDLE, ST_IGNORE: begin
                        // deaf until the next start
                        sdaOe <= 1'h0;
                    end
                    ST_RXBYTE: begin
                        if (sclRise) begin
                            bitCnt_r <= bitCnt_r + 3'h1;
                        end
                        if (byteDone) begin
                            state_r <= ST_RXACK;
                            toTx_r  <= 1'h0;
                            case (kind_r)
                                KD_DEV: begin
                                    if (devMatch) begin
                                        toTx_r <= (rxShift_r[0]
                                                   == EES_DIR_READ);
                                        kind_r <= KD_ADRH;
                                    end else begin
                                        // no match or busy: nack
                                        state_r <= ST_IGNORE;
                                    end
                                end
                                KD_ADRH: begin
                                    // upper bits above twelve dropped
                                    addr_r[EES_ADDR_W-1:8]
                                        <= rxShift_r[EES_HI_W-1:0];
                                    kind_r <= KD_ADRL;
                                end
                                KD_ADRL: begin
                                    addr_r[7:0] <= rxShift_r;
                                    kind_r      <= KD_DATA;
                                end
                                default: begin
                                    if (wpLat_r) begin
                                        // protected: nack, discard
                                        state_r <= ST_IGNORE;
                                    end else begin
                                        // offset wraps, page stays
                                        addr_r[EES_OFF_W-1:0]
                                            <= offNext;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_RXACK: begin
                        if (sclFall && !sdaOe) begin
                            // ninth bit: pull low to acknowledge
                            sdaOe <= 1'h1;
                        end else if (txLoad) begin
                            // read direction: first byte follows
                            sdaOe    <= ~memByte[7];
                            txSh_r   <= {memByte[6:0], 1'h1};
                            addr_r   <= addr_r + 12'h001;
                            bitCnt_r <= 3'h0;
                            state_r  <= ST_TXBYTE;
                        end else if (sclFall) begin
                            // release and take the next byte
                            sdaOe    <= 1'h0;
                            bitCnt_r <= 3'h0;
                            state_r  <= ST_RXBYTE;
                        end
                    end
                    ST_TXBYTE: begin
                        if (sclRise) begin
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (bitCnt_r == EES_LAST_BIT) begin
                                state_r  <= ST_TXACK;
                                gotAck_r <= 1'h0;
                            end
                        end else if (sclFall) begin
                            // next bit only after the fall
                            sdaOe  <= ~txSh_r[7];
                            txSh_r <= {txSh_r[6:0], 1'h1};
                        end
                    end
                    ST_TXACK: begin
                        if (sclRise) begin
                            if (sync2_r.sda) begin
                                // nack: wait for the stop
                                state_r <= ST_IGNORE;
                            end else begin
                                gotAck_r <= 1'h1;
                            end
                        end else if (txLoad) begin
                            // master acked: send the next byte
                            // pointer wraps to zero at the end
                            sdaOe    <= ~memByte[7];
                            txSh_r   <= {memByte[6:0], 1'h1};
                            addr_r   <= addr_r + 12'h001;
                            bitCnt_r <= 3'h0;
                            gotAck_r <= 1'h0;
                            state_r  <= ST_TXBYTE;
                        end else if (sclFall) begin
                            // release for the master's ack bit
                            sdaOe <= 1'h0;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        sdaOe   <= 1'h0;
                    end
                endcase
            end
        end
    end

    // only the enable moves; the driven level is always low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'h0;
        end else if (ce) begin
            sdaOut <= 1'h0;
        end
    end

    // protect pin strobe, cleared by each new start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wpLat_r <= 1'h0;
        end else if (ce) begin
            if (startEv) begin
                wpLat_r <= 1'h0;
            end else if (wpStrobe) begin
                wpLat_r <= sync2_r.wp;
            end
        end
    end

    // page buffer data; no reset needed, valid bits guard it
    always_ff @(posedge clk) begin
        if (ce && storeEv) begin
            pageBuf[addr_r[EES_OFF_W-1:0]] <= rxShift_r;
        end
    end

    // loaded-offset mask; a late byte just overwrites its slot
    // a start during the write cycle must not lose the page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_r <= '0;
        end else if (ce) begin
            if (commitAct_r && (commitIdx_r == EES_LAST_OFF)) begin
                valid_r <= '0;
            end else if (startEv && !writeBusy) begin
                valid_r <= '0;
            end else if (storeEv) begin
                valid_r[addr_r[EES_OFF_W-1:0]] <= 1'h1;
            end
        end
    end

    // write cycle: launched by stop, timed, then ack again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            writeBusy   <= 1'h0;
            busyCnt_r   <= '0;
            commitAct_r <= 1'h0;
            commitIdx_r <= '0;
        end else if (ce) begin
            if (writeBusy) begin
                busyCnt_r <= busyCnt_r + 20'h00001;
                if (busyCnt_r == EES_BUSY_W'(WRITE_CYCLES - 1)) begin
                    writeBusy <= 1'h0;
                end
            end else if (stopEv && (valid_r != '0)) begin
                writeBusy   <= 1'h1;
                busyCnt_r   <= '0;
                commitAct_r <= 1'h1;
                commitIdx_r <= '0;
            end
            if (commitAct_r) begin
                commitIdx_r <= commitIdx_r + 5'h01;
                if (commitIdx_r == EES_LAST_OFF) begin
                    commitAct_r <= 1'h0;
                end
            end
        end
    end

    // one buffer slot per cycle; 32 cycles, far inside the timer
    always_ff @(posedge clk) begin
        if (ce && commitAct_r && valid_r[commitIdx_r]) begin
            mem[{addr_r[EES_ADDR_W-1:EES_OFF_W], commitIdx_r}]
                <= pageBuf[commitIdx_r];
        end
    end

    // checks on the clk domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_idle_quiet: assert property (
        (state_r == ST_IDLE) |-> !sdaOe)
        else $error("line driven while idle");

    a_busy_deaf: assert property (
        writeBusy |-> !sdaOe)
        else $error("line driven during write cycle");

    a_oe_fall_only: assert property (
        ce && $changed(sdaOe) |->
            ($past(sclFall) || $past(startEv) || $past(stopEv)))
        else $error("sda changed away from an scl fall");

    a_stop_launch: assert property (
        ce && stopEv && !writeBusy && (valid_r != '0) |=> writeBusy)
        else $error("stop did not launch write cycle");

    a_busy_min: assert property (
        ce && $rose(writeBusy) |-> writeBusy [*8])
        else $error("write cycle ended too early");

    a_busy_end: assert property (
        $fell(writeBusy) |->
            ($past(busyCnt_r) == EES_BUSY_W'(WRITE_CYCLES - 1)))
        else $error("write cycle length wrong");

    a_dev_nomatch: assert property (
        ce && byteDone && (kind_r == KD_DEV) && !devMatch |=>
            (state_r == ST_IGNORE) && !sdaOe)
        else $error("unmatched address acknowledged");

    a_wp_nack: assert property (
        ce && byteDone && (kind_r == KD_DATA) && wpLat_r |=>
            (state_r == ST_IGNORE) ##1 !sdaOe)
        else $error("protected data byte acknowledged");

    a_read_wrap: assert property (
        ce && txLoad && (addr_r == 12'hfff) |=> (addr_r == 12'h000))
        else $error("read pointer did not wrap");

    a_page_wrap: assert property (
        ce && storeEv |=>
            (addr_r[EES_ADDR_W-1:EES_OFF_W]
             == $past(addr_r[EES_ADDR_W-1:EES_OFF_W])))
        else $error("page part moved during page write");

    // main scenarios
    c_write_cycle: cover property ($rose(writeBusy));
    c_seq_read: cover property (
        (state_r == ST_TXACK) && gotAck_r ##[1:300] txLoad);
    c_wp_reject: cover property (byteDone && (kind_r == KD_DATA)
                                 && wpLat_r);
    c_page_wrap: cover property (storeEv
        && (addr_r[EES_OFF_W-1:0] == EES_LAST_OFF));

endmodule

`default_nettype wire

// >>> ees_slave_tb_top.sv
// self-checking bench for the eeprom slave, master model on the link
// assumes WRITE_CYCLES shortened so ack polling sees a busy device
`timescale 1ns/100ps
`default_nettype none

module ees_slave_tb_top;
    import ees_pkg::*;
    localparam int         WCYC  = 1000;   // write cycle in clk cycles
    logic [2:0] strap;                     // strap pins of this device

    logic clk, rst, ce, wp, sdaOe, sdaOut, busy, mPull, sclW, sdaW, a;
    logic [7:0] d;
    int   errCount, compares, cyc;

    // open-drain wire with pull-up
    assign sdaW = (sdaOe ? sdaOut : 1'b1) & !mPull;

    ees_i2c_master mst_u (.sclOut(sclW), .sdaPull(mPull), .sdaWire(sdaW));

    ees_slave #(.WRITE_CYCLES(WCYC)) dut_u (
        .clk(clk), .rst(rst), .ce(ce), .scl(sclW), .sdaIn(sdaW),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(wp),
        .strapSelectBit0(strap[0]), .strapSelectBit1(strap[1]),
        .strapSelectBit2(strap[2]), .writeBusy(busy));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errCount++;
            closeOut();
        end
    end

    task automatic closeOut;
        if (errCount == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            errCount++;
        end
    endtask

    function automatic logic [7:0] dev(input logic dir);
        return {EES_DEV_PREFIX, strap, dir};
    endfunction

    // start, write-direction device byte, both address bytes
    task automatic setAddr(input logic [7:0] hi, lo);
        mst_u.startF(1'b0);
        mst_u.send(dev(1'b0), a);
        chk("devAck", 1, a);
        mst_u.send(hi, a);
        chk("hiAck", 1, a);
        mst_u.send(lo, a);
        chk("loAck", 1, a);
    endtask

    // page write across the page end, polled while busy
    task automatic tWrite;
        setAddr(8'hff, 8'hfe);
        mst_u.send(8'h3c, a);
        chk("d0Ack", 1, a);
        mst_u.send(8'hc3, a);
        chk("d1Ack", 1, a);
        mst_u.send(8'h96, a);
        chk("d2Ack", 1, a);
        mst_u.stopF();
        chk("busyOn", 1, busy);
        mst_u.startF(1'b0);
        mst_u.send(dev(1'b0), a);
        chk("busyNack", 0, a);
        mst_u.stopF();
        // freeze the timer; an unfrozen one would have ended by now
        @(posedge clk) #1 ce = 1'b0;
        repeat (600) @(posedge clk);
        #1 ce = 1'b1;
        chk("ceFreeze", 1, busy);
        for (int i = 0; i < 1200 && busy === 1'b1; i++) @(posedge clk);
        #1;
        chk("busyOff", 0, busy);
        mst_u.startF(1'b0);
        mst_u.send(dev(1'b0), a);
        chk("pollAck", 1, a);
        mst_u.stopF();
    endtask

    // selective then sequential read wrapping past the last byte
    task automatic tRead;
        setAddr(8'h0f, 8'hfe);
        mst_u.startF(1'b1);
        mst_u.send(dev(1'b1), a);
        chk("rdAck", 1, a);
        mst_u.recv(1'b1, d);
        chk("rdFfe", 8'h3c, d);
        mst_u.recv(1'b1, d);
        chk("rdFff", 8'hc3, d);
        mst_u.recv(1'b0, d);
        chk("rd000", EES_ERASED, d);
        mst_u.stopF();
        setAddr(8'h0f, 8'he0);
        mst_u.startF(1'b1);
        mst_u.send(dev(1'b1), a);
        mst_u.recv(1'b0, d);
        chk("rdFe0", 8'h96, d);
        mst_u.stopF();
        mst_u.startF(1'b0);
        mst_u.send(dev(1'b1), a);
        chk("immAck", 1, a);
        mst_u.recv(1'b0, d);
        chk("rdFe1", EES_ERASED, d);
        mst_u.stopF();
    endtask

    // protect pin high refuses data; wrong strap refused
    task automatic tProtect;
        @(posedge clk) #1 wp = 1'b1;
        setAddr(8'h01, 8'h00);
        mst_u.send(8'h5a, a);
        chk("wpNack", 0, a);
        mst_u.stopF();
        chk("wpBusy", 0, busy);
        @(posedge clk) #1 wp = 1'b0;
        setAddr(8'h01, 8'h00);
        mst_u.startF(1'b1);
        mst_u.send(dev(1'b1), a);
        mst_u.recv(1'b0, d);
        chk("wpData", EES_ERASED, d);
        mst_u.stopF();
        @(posedge clk) #1 strap = 3'h4;
        mst_u.startF(1'b0);
        mst_u.send({EES_DEV_PREFIX, 3'h4, 1'b0}, a);
        chk("strapAck", 1, a);
        mst_u.stopF();
        @(posedge clk) #1 strap = 3'h5;
        mst_u.startF(1'b0);
        mst_u.send({EES_DEV_PREFIX, 3'h4, 1'b0}, a);
        chk("strapNack", 0, a);
        mst_u.stopF();
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        ce  = 1'b1;
        wp  = 1'b0;
        strap = 3'h5;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("rstOe", 0, sdaOe);
        chk("rstBusy", 0, busy);
        tWrite();
        tRead();
        tProtect();
        closeOut();
    end
endmodule

`default_nettype wire
